// file: design/thermal_alert_pkg.sv
// shared constants and types for the thermal alert monitor
package thermal_alert_pkg;
  localparam int TEMP_W = 8;
  localparam logic [7:0] SPURIOUS_BAND = 8'h08;
  localparam int CONV_PERIOD_US = 100;
  localparam int CLK_MHZ = 25;
  localparam int CONV_CYCLES = CONV_PERIOD_US * CLK_MHZ;
  localparam logic [7:0] UPPER_RESET = 8'h7f;
  localparam logic [7:0] LOWER_RESET = 8'h80;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam int FLAG_LOCAL_OVER = 0;
  localparam int FLAG_LOCAL_UNDER = 1;
  localparam int FLAG_REMOTE_OVER = 2;
  localparam int FLAG_REMOTE_UNDER = 3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_COMPARE = 2'b11
  } conv_state_t;
endpackage

// file: design/limit_cmp_if.sv
// comparison request and verdict between monitor and comparator
`timescale 1ns/1ps
interface limit_cmp_if;
  logic signed [7:0] reading;
  logic signed [7:0] previous;
  logic signed [7:0] upper;
  logic signed [7:0] lower;
  logic over;
  logic under;
  logic near_limit;
  logic changed;
  modport mon (output reading, previous, upper, lower, input over, under, near_limit, changed);
  modport cmp (input reading, previous, upper, lower, output over, under, near_limit, changed);
endinterface

// file: design/limit_comparator.sv
// signed limit comparison and near-limit band detection
`timescale 1ns/1ps
module limit_comparator (
  limit_cmp_if.cmp cmp
);
  function automatic logic within_band(input logic signed [7:0] a, input logic signed [7:0] b);
    logic signed [8:0] d;
    d = 9'(a) - 9'(b);
    if (d < 0) begin
      d = -d;
    end
    return d <= 9'(thermal_alert_pkg::SPURIOUS_BAND);
  endfunction

  assign cmp.over = cmp.reading > cmp.upper;
  assign cmp.under = cmp.reading < cmp.lower;
  assign cmp.near_limit = within_band(cmp.reading, cmp.upper)
    || within_band(cmp.reading, cmp.lower);
  assign cmp.changed = cmp.reading != cmp.previous;
endmodule

// file: design/thermal_alert_monitor.sv
// thermal alert monitor: limit compare, cause flags, active-low alert
// Operation
// - the alert is driven active whenever a reading lies beyond the upper or lower limit.
// - raising an alert sets the flag for its cause: local over, local under, remote over, remote under.
// - in auto-convert mode a changed reading within 8 degrees of a limit may raise a false alert.
// - a false alert sets its matching cause flag too, so flags alone are not trustworthy.
// - at most one false alert can follow any single conversion.
`timescale 1ns/1ps
module thermal_alert_monitor #(
  parameter int CONV_CYCLES = thermal_alert_pkg::CONV_CYCLES,
  parameter bit MODEL_DEFECT = 1'b1
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic i_auto_convert,
  input wire logic i_one_shot,
  input wire logic [7:0] i_local_temp,
  input wire logic [7:0] i_remote_temp,
  input wire logic [7:0] i_upper_alarm_limit,
  input wire logic [7:0] i_lower_alarm_limit,
  input wire logic i_status_read,
  output logic o_alert_n,
  output logic o_local_over_limit_flag,
  output logic o_local_under_limit_flag,
  output logic o_remote_over_limit_flag,
  output logic o_remote_under_limit_flag,
  output logic [7:0] o_local_reading,
  output logic [7:0] o_remote_reading,
  output logic o_conv_done
);
  localparam int CNT_W = $clog2(CONV_CYCLES + 1);

  // temperatures arrive from the analog front end, off this clock
  // per-bit sync may tear a word that moves mid-sync; the source holds it
  logic [7:0] loc_s1_reg;
  logic [7:0] loc_s2_reg;
  logic [7:0] rem_s1_reg;
  logic [7:0] rem_s2_reg;
  logic auto_s1_reg;
  logic auto_s2_reg;
  logic shot_s1_reg;
  logic shot_s2_reg;
  logic shot_d_reg;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      loc_s1_reg <= 8'h00;
      loc_s2_reg <= 8'h00;
      rem_s1_reg <= 8'h00;
      rem_s2_reg <= 8'h00;
      auto_s1_reg <= 1'b0;
      auto_s2_reg <= 1'b0;
      shot_s1_reg <= 1'b0;
      shot_s2_reg <= 1'b0;
      shot_d_reg <= 1'b0;
    end else begin
      loc_s1_reg <= i_local_temp;
      loc_s2_reg <= loc_s1_reg;
      rem_s1_reg <= i_remote_temp;
      rem_s2_reg <= rem_s1_reg;
      auto_s1_reg <= i_auto_convert;
      auto_s2_reg <= auto_s1_reg;
      shot_s1_reg <= i_one_shot;
      shot_s2_reg <= shot_s1_reg;
      shot_d_reg <= shot_s2_reg;
    end
  end
  logic shot_rise;
  assign shot_rise = shot_s2_reg && !shot_d_reg;

  // conversion rate divider
  // held at zero outside auto mode, so the first tick is a full period away
  logic [CNT_W-1:0] div_reg;
  logic conv_tick;
  assign conv_tick = auto_s2_reg && (div_reg == CNT_W'(CONV_CYCLES - 1));
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      div_reg <= '0;
    end else if (!auto_s2_reg || conv_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + CNT_W'(1);
    end
  end

  // conversion sequence: sample, then compare local and remote together
  // triggers outside idle are dropped, so a conversion never restarts
  thermal_alert_pkg::conv_state_t state_reg;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= thermal_alert_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        thermal_alert_pkg::ST_IDLE: begin
          if (conv_tick || shot_rise) begin
            state_reg <= thermal_alert_pkg::ST_SAMPLE;
          end
        end
        thermal_alert_pkg::ST_SAMPLE: state_reg <= thermal_alert_pkg::ST_COMPARE;
        thermal_alert_pkg::ST_COMPARE: state_reg <= thermal_alert_pkg::ST_IDLE;
        default: state_reg <= thermal_alert_pkg::ST_IDLE;
      endcase
    end
  end
  logic in_compare;
  assign in_compare = state_reg == thermal_alert_pkg::ST_COMPARE;

  logic [7:0] loc_prev_reg;
  logic [7:0] rem_prev_reg;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      o_local_reading <= 8'h00;
      o_remote_reading <= 8'h00;
      loc_prev_reg <= 8'h00;
      rem_prev_reg <= 8'h00;
    end else if (state_reg == thermal_alert_pkg::ST_SAMPLE) begin
      o_local_reading <= loc_s2_reg;
      o_remote_reading <= rem_s2_reg;
      loc_prev_reg <= o_local_reading;
      rem_prev_reg <= o_remote_reading;
    end
  end

  limit_cmp_if lc ();
  limit_cmp_if rc ();
  assign lc.reading = o_local_reading;
  assign lc.previous = loc_prev_reg;
  assign lc.upper = i_upper_alarm_limit;
  assign lc.lower = i_lower_alarm_limit;
  assign rc.reading = o_remote_reading;
  assign rc.previous = rem_prev_reg;
  assign rc.upper = i_upper_alarm_limit;
  assign rc.lower = i_lower_alarm_limit;
  limit_comparator u_loc (.cmp(lc));
  limit_comparator u_rem (.cmp(rc));

  // false-alert model: auto mode, changed reading, near a limit; one per
  // conversion at most, and only on every other auto-mode conversion to stay below rate
  logic defect_phase_reg;
  logic loc_false;
  logic rem_false;
  assign loc_false = MODEL_DEFECT && auto_s2_reg && lc.changed && lc.near_limit
    && !lc.over && !lc.under && defect_phase_reg;
  assign rem_false = MODEL_DEFECT && auto_s2_reg && rc.changed && rc.near_limit
    && !rc.over && !rc.under && defect_phase_reg && !loc_false;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      defect_phase_reg <= 1'b0;
    end else if (in_compare && auto_s2_reg) begin
      defect_phase_reg <= !defect_phase_reg;
    end
  end

  // false hits point at the limit nearer to the reading
  function automatic logic nearer_upper(input logic [7:0] r, input logic [7:0] u,
                                        input logic [7:0] l);
    logic signed [8:0] du;
    logic signed [8:0] dl;
    du = 9'($signed(u)) - 9'($signed(r));
    dl = 9'($signed(r)) - 9'($signed(l));
    return du <= dl;
  endfunction

  logic [3:0] set_vec;
  always_comb begin
    set_vec = 4'h0;
    if (in_compare) begin
      set_vec[thermal_alert_pkg::FLAG_LOCAL_OVER] = lc.over;
      set_vec[thermal_alert_pkg::FLAG_LOCAL_UNDER] = lc.under;
      set_vec[thermal_alert_pkg::FLAG_REMOTE_OVER] = rc.over;
      set_vec[thermal_alert_pkg::FLAG_REMOTE_UNDER] = rc.under;
      if (loc_false) begin
        if (nearer_upper(o_local_reading, i_upper_alarm_limit, i_lower_alarm_limit)) begin
          set_vec[thermal_alert_pkg::FLAG_LOCAL_OVER] = 1'b1;
        end else begin
          set_vec[thermal_alert_pkg::FLAG_LOCAL_UNDER] = 1'b1;
        end
      end
      if (rem_false) begin
        if (nearer_upper(o_remote_reading, i_upper_alarm_limit, i_lower_alarm_limit)) begin
          set_vec[thermal_alert_pkg::FLAG_REMOTE_OVER] = 1'b1;
        end else begin
          set_vec[thermal_alert_pkg::FLAG_REMOTE_UNDER] = 1'b1;
        end
      end
    end
  end

  // a read clears only what no longer holds; a set in the same cycle wins
  // a still-crossed limit keeps its flag, so a read cannot lose a real alarm
  logic [3:0] flags_reg;
  logic [3:0] still_vec;
  assign still_vec = {rc.under, rc.over, lc.under, lc.over};
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      flags_reg <= thermal_alert_pkg::FLAGS_RESET;
    end else if (i_status_read) begin
      flags_reg <= set_vec | still_vec;
    end else begin
      flags_reg <= flags_reg | set_vec;
    end
  end

  // done rises together with the flags, one cycle after the compare
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      o_conv_done <= 1'b0;
    end else begin
      o_conv_done <= in_compare;
    end
  end

  // plain nor of the sticky flags, so alert and flags never disagree
  assign o_alert_n = ~|flags_reg;
  assign o_local_over_limit_flag = flags_reg[thermal_alert_pkg::FLAG_LOCAL_OVER];
  assign o_local_under_limit_flag = flags_reg[thermal_alert_pkg::FLAG_LOCAL_UNDER];
  assign o_remote_over_limit_flag = flags_reg[thermal_alert_pkg::FLAG_REMOTE_OVER];
  assign o_remote_under_limit_flag = flags_reg[thermal_alert_pkg::FLAG_REMOTE_UNDER];
endmodule

// file: testbench/thermal_alert_monitor_asserts.sv
// port-level checks for the thermal alert monitor
`timescale 1ns/1ps
module thermal_alert_monitor_asserts #(
  parameter int CONV_CYCLES = 8
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic i_auto_convert,
  input wire logic i_one_shot,
  input wire logic [7:0] i_local_temp,
  input wire logic [7:0] i_remote_temp,
  input wire logic [7:0] i_upper_alarm_limit,
  input wire logic [7:0] i_lower_alarm_limit,
  input wire logic i_status_read,
  input wire logic o_alert_n,
  input wire logic o_local_over_limit_flag,
  input wire logic o_local_under_limit_flag,
  input wire logic o_remote_over_limit_flag,
  input wire logic o_remote_under_limit_flag,
  input wire logic [7:0] o_local_reading,
  input wire logic [7:0] o_remote_reading,
  input wire logic o_conv_done
);
  wire logic [3:0] flags = {o_remote_under_limit_flag, o_remote_over_limit_flag,
    o_local_under_limit_flag, o_local_over_limit_flag};
  wire logic signed [8:0] lr = {o_local_reading[7], o_local_reading};
  wire logic signed [8:0] rr = {o_remote_reading[7], o_remote_reading};
  wire logic signed [8:0] up = {i_upper_alarm_limit[7], i_upper_alarm_limit};
  wire logic signed [8:0] lo = {i_lower_alarm_limit[7], i_lower_alarm_limit};
  // 9 bits so the distance to a limit cannot wrap
  wire logic near_l = (lr - up <= 8 && up - lr <= 8) || (lr - lo <= 8 && lo - lr <= 8);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  sequence s_read_in_range; i_status_read && !o_conv_done && lr <= up && lr >= lo; endsequence
  property p_alert_nor; o_alert_n == (flags == 4'h0); endproperty
  a_alert_nor: assert property (p_alert_nor) else $error("alert not tied to flags");
  property p_set_at_done; (flags & ~$past(flags)) != 4'h0 |-> o_conv_done; endproperty
  a_set_at_done: assert property (p_set_at_done) else $error("flag rose off a conversion");
  property p_local_over; o_conv_done && lr > up |-> o_local_over_limit_flag; endproperty
  a_local_over: assert property (p_local_over) else $error("local over missed");
  property p_remote_under; o_conv_done && rr < lo |-> o_remote_under_limit_flag; endproperty
  a_remote_under: assert property (p_remote_under) else $error("remote under missed");
  property p_false_band; $rose(o_local_over_limit_flag) |-> lr > up || near_l; endproperty
  a_false_band: assert property (p_false_band) else $error("flag far from limits");
  property p_hold; !$past(i_status_read) |-> (flags & $past(flags)) == $past(flags); endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without read");
  property p_clear; s_read_in_range |=> !o_local_over_limit_flag || o_conv_done; endproperty
  a_clear: assert property (p_clear) else $error("flag kept after read");
  property p_done_pulse; o_conv_done |=> !o_conv_done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
endmodule

// file: testbench/thermal_ctrl_model.sv
// servicing controller: trusts readings, not flags, before acting
`timescale 1ns/1ps
module thermal_ctrl_model #(
  parameter logic [1:0] DELAY = 2'h2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_alert_n,
  input wire logic [7:0] i_local_reading,
  input wire logic [7:0] i_remote_reading,
  input wire logic [7:0] i_upper,
  input wire logic [7:0] i_lower,
  output logic o_status_read,
  output int o_real_events
);
  logic [1:0] wait_reg;
  logic crossed;
  // flags may be false, so only the readings decide
  assign crossed = $signed(i_local_reading) > $signed(i_upper) ||
    $signed(i_local_reading) < $signed(i_lower) || $signed(i_remote_reading) > $signed(i_upper) ||
    $signed(i_remote_reading) < $signed(i_lower);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_reg <= 2'h0;
      o_status_read <= 1'b0;
      o_real_events <= 0;
    end else begin
      wait_reg <= i_alert_n ? 2'h0 : wait_reg + 2'h1;
      o_status_read <= !i_alert_n && wait_reg == DELAY;
      if (!i_alert_n && wait_reg == DELAY && crossed) begin
        o_real_events <= o_real_events + 1;
      end
    end
  end
endmodule

// file: testbench/test_thermal_alert_monitor.sv
// self-checking bench for the thermal alert monitor
`timescale 1ns/1ps
module test_thermal_alert_monitor;
  localparam int CONV_CYCLES = 8;
  logic clk = 1'b0, rst = 1'b1, auto_cv = 1'b0, one_shot = 1'b0;
  logic [7:0] lt = 8'h10, rt = 8'h10, up = 8'h1e, lo = 8'h05;
  logic [7:0] cl [7] = '{8'h28, 8'h02, 8'h10, 8'h10, 8'h1e, 8'hf0, 8'h05};
  logic [7:0] cr [7] = '{8'h10, 8'h10, 8'h28, 8'h80, 8'h10, 8'h10, 8'h7f};
  wire logic rd, alert_n, lof, luf, rof, ruf, done;
  wire logic [7:0] lrd, rrd;
  int miscompares = 0, samples_checked = 0, falls = 0, real_ev, real0;
  thermal_alert_monitor #(.CONV_CYCLES(CONV_CYCLES)) uut (.I_CORE_CLK(clk), .I_RST(rst),
    .i_auto_convert(auto_cv), .i_one_shot(one_shot), .i_local_temp(lt), .i_remote_temp(rt),
    .i_upper_alarm_limit(up), .i_lower_alarm_limit(lo), .i_status_read(rd),
    .o_alert_n(alert_n), .o_local_over_limit_flag(lof), .o_local_under_limit_flag(luf),
    .o_remote_over_limit_flag(rof), .o_remote_under_limit_flag(ruf),
    .o_local_reading(lrd), .o_remote_reading(rrd), .o_conv_done(done));
  thermal_ctrl_model ctrl (.i_clk(clk), .i_rst(rst), .i_alert_n(alert_n), .i_local_reading(lrd),
    .i_remote_reading(rrd), .i_upper(up), .i_lower(lo), .o_status_read(rd),
    .o_real_events(real_ev));
  initial forever #20 clk = ~clk;
  function automatic logic [3:0] expect_flags(input logic [7:0] l, r);
    return {$signed(r) < $signed(lo), $signed(r) > $signed(up),
      $signed(l) < $signed(lo), $signed(l) > $signed(up)};
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 30);
    chk({7'h0, done}, 8'h01);
  endtask
  // one-shot conversion; flags checked only when no stale cause remains
  task automatic convert(input logic [7:0] l, r, input bit ck);
    @(posedge clk);
    lt <= l;
    rt <= r;
    repeat (3) @(posedge clk);
    one_shot <= 1'b1;
    wait_done;
    chk(lrd, l);
    chk(rrd, r);
    if (ck) chk({4'h0, ruf, rof, luf, lof}, {4'h0, expect_flags(l, r)});
    if (ck) chk({7'h0, alert_n}, {7'h0, expect_flags(l, r) == 4'h0});
    @(posedge clk);
    one_shot <= 1'b0;
  endtask
  // eight auto conversions, toggling the given bits after each; false hits point at ef
  task automatic auto_run(input logic [7:0] lx, rx, input logic [3:0] ef);
    falls = 0;
    for (int i = 0; i < 8; i++) begin
      wait_done;
      if (alert_n === 1'b0) begin
        falls++;
        chk({4'h0, ruf, rof, luf, lof}, {4'h0, ef});
      end
      @(posedge clk);
      lt <= lt ^ lx;
      rt <= rt ^ rx;
    end
    chk({7'h0, falls inside {[1:4]}}, 8'h01);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      convert(cl[i], cr[i], 1'b1);
      repeat (10) @(posedge clk);
      #1;
      chk({4'h0, ruf, rof, luf, lof}, {4'h0, expect_flags(cl[i], cr[i])});
      convert(8'h10, 8'h10, 1'b0);
      repeat (10) @(posedge clk);
      #1;
      chk({7'h0, alert_n}, 8'h01);
    end
    // local near the upper limit, then remote near the lower one, changing each conversion
    real0 = real_ev;
    @(posedge clk);
    lt <= 8'h18;
    auto_cv <= 1'b1;
    auto_run(8'h01, 8'h00, 4'h1);
    @(posedge clk);
    lt <= 8'h10;
    rt <= 8'h08;
    auto_run(8'h00, 8'h01, 4'h8);
    auto_cv <= 1'b0;
    chk(8'(real_ev - real0), 8'h00);
    end_of_test;
  end
  initial begin
    #400000;
    miscompares++;
    end_of_test;
  end
endmodule
bind thermal_alert_monitor thermal_alert_monitor_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .i_auto_convert(i_auto_convert),
  .i_one_shot(i_one_shot), .i_local_temp(i_local_temp), .i_remote_temp(i_remote_temp),
  .i_upper_alarm_limit(i_upper_alarm_limit), .i_lower_alarm_limit(i_lower_alarm_limit),
  .i_status_read(i_status_read), .o_alert_n(o_alert_n),
  .o_local_over_limit_flag(o_local_over_limit_flag),
  .o_local_under_limit_flag(o_local_under_limit_flag),
  .o_remote_over_limit_flag(o_remote_over_limit_flag),
  .o_remote_under_limit_flag(o_remote_under_limit_flag),
  .o_local_reading(o_local_reading), .o_remote_reading(o_remote_reading),
  .o_conv_done(o_conv_done));
